// >>> sfp_pkg.sv
/*
 * shared constants and carrier types for the serial register port
 * with fault latch, live status, mask and fault pin.
 * assumes one core clock; all pin inputs are asynchronous to it.
 */
package sfp_pkg;

    ////////////////////////////////////////////////////////////////////
    // register addresses (8-bit frame address field)
    localparam logic [7:0] ADDR_NOP         = 8'h00;
    localparam logic [7:0] ADDR_FAULT_LATCH = 8'h3f;
    localparam logic [7:0] ADDR_FAULT_MASK  = 8'h40;
    localparam logic [7:0] ADDR_LIVE_FAULT  = 8'h41;
    localparam logic [7:0] ADDR_HEAT_RESET  = 8'h42;
    localparam logic [7:0] ADDR_RB_SELECT   = 8'h64;
    localparam logic [7:0] ADDR_CMD_KEY     = 8'h66;

    ////////////////////////////////////////////////////////////////////
    // data values and keys
    localparam logic [15:0] KEY_FIRST  = 16'h15fa;
    localparam logic [15:0] KEY_SECOND = 16'haf51;
    localparam logic [15:0] CLEAR_ALL  = 16'hffff;
    localparam logic [15:0] REG_RESET  = 16'h0000;

    ////////////////////////////////////////////////////////////////////
    // fault bit positions (latch, live and mask share one layout)
    localparam int BIT_FRAME_ERR = 0;
    localparam int BIT_DIE_HOT   = 1;
    localparam int BIT_SUPPLY0   = 2;
    localparam int NUM_SUPPLY    = 6;
    localparam int BIT_MODEM     = 8;
    localparam int BIT_CHAN      = 9;

    // readback select and heat reset fields
    localparam int RB_PTR_MSB     = 6;
    localparam int RB_ADDR_MSB    = 7;
    localparam int RB_STATUS_SEL  = 8;
    localparam int HEAT_EN_BIT    = 0;

    ////////////////////////////////////////////////////////////////////
    // frame layout and check
    localparam logic [5:0] FRAME_BITS = 6'h20;
    localparam logic [5:0] CNT_MAX    = 6'h3f;
    localparam logic [7:0] CRC_POLY   = 8'h07;
    localparam logic [7:0] CRC_INIT   = 8'h00;

    ////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [5:0] supply_low;
        logic       die_hot;
        logic       die_reset;
        logic       modem_fault;
        logic       conv_done;
        logic       comp_level;
        logic       chan_fault;
    } sfp_cond_t;

    typedef struct packed {
        logic      sclk;
        logic      cs_n;
        logic      sdi;
        logic      pin_in;
        sfp_cond_t cond;
    } sfp_pins_t;

    typedef struct packed {
        sfp_pins_t   meta;
        sfp_pins_t   sync;
        logic        sclk_prev;
        logic        cs_prev;
        logic [31:0] rx;
        logic [5:0]  cnt;
        logic [31:0] tx;
        logic        sdo;
        logic [15:0] latch;
        logic [15:0] mask;
        logic        heat_en;
        logic [15:0] rbsel;
        logic        key_armed;
        logic        rst_req;
        logic        pin_oe;
    } sfp_state_t;

endpackage

// >>> sfp_crc8.sv
/*
 * combinational crc-8 over a 24-bit word, msb first.
 * assumes the caller registers the result where timing matters.
 */
`timescale 1ns/10ps
module sfp_crc8 import sfp_pkg::*; (
    // word in
    input  wire logic [23:0] data,
    // check byte out
    output logic      [7:0]  crc
);

    logic fb;

    // bitwise long division by the polynomial
    always_comb begin
        crc = CRC_INIT;
        fb  = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            fb  = crc[7] ^ data[i];
            crc = {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        end
    end

endmodule

// >>> sfp_core.sv
/*
 * serial register port with fault latch, live status, mask, fault pin,
 * command key soft reset and heat reset.
 * assumes sclk, cs_n, sdi, the fault pin level and all conditions are
 * asynchronous; sclk is far slower than core_clk (two-stage sampling).
 */
`timescale 1ns/10ps
// Contract
// RULE1: any fault drives pin, sets latch bit
// RULE2: latch bits clear by writing one
// RULE3: host clears sub-registers before main latch; no sub-registers here, latch bits are cleared directly
// RULE4: live register follows conditions, unlatched
// RULE5: masked bits never drive fault pin
// RULE6: six supply lows set latch bits
// RULE7: die hot sets its latch bit
// RULE8: heat reset only when enabled
// RULE9: four-wire port, crc-8, straight binary
// RULE10: 32-bit shift in, msb first, falling
// RULE11: address, data, crc field layout
// RULE12: read starts with select write 0x64
// RULE13: second frame shifts readback word out
// RULE14: bit31 one at cs fall, rest rising
// RULE15: data in 23:8, crc in 7:0
// RULE16: select zero returns pointer in 30:24
// RULE17: select one returns status flags
// RULE18: bad crc discarded, error flagged
// RULE19: only 32 falling edges accepted
// RULE20: two key writes give soft reset
// RULE21: act at cs rise, restart count
module sfp_core import sfp_pkg::*; (
    // clock and reset
    input  wire logic      core_clk,
    input  wire logic      rst,
    // serial port pins
    input  wire logic      sclk,
    input  wire logic      cs_n,
    input  wire logic      sdi,
    output logic           sdo,
    // open-drain fault pin
    input  wire logic      fault_pin_i,
    output logic           fault_pin_o,
    output logic           fault_pin_oe,
    // monitored conditions
    input  wire sfp_cond_t cond,
    // full device reset request
    output logic           dev_reset
);

    sfp_state_t  s_q;
    sfp_state_t  s_d;
    sfp_pins_t   pins;
    logic        cs_fall;
    logic        cs_rise;
    logic        sclk_fall;
    logic        sclk_rise;
    logic [7:0]  crc_rx;
    logic [7:0]  crc_tx;
    logic        crc_ok;
    logic        len_ok;
    logic        wr_fire;
    logic        frame_err;
    logic [7:0]  wr_addr;
    logic [15:0] wr_data;
    logic [15:0] live;
    logic [15:0] rd_data;
    logic [6:0]  mid;
    logic [23:0] tx_head;
    logic        key_hit;

    ////////////////////////////////////////////////////////////////////
    // pin bundle and edge detect on the second sampling stage
    assign pins      = '{sclk: sclk, cs_n: cs_n, sdi: sdi, pin_in: fault_pin_i, cond: cond};
    assign cs_fall   = s_q.cs_prev & ~s_q.sync.cs_n;
    assign cs_rise   = ~s_q.cs_prev & s_q.sync.cs_n;
    // RULE10: sample on falling
    assign sclk_fall = ~s_q.sync.cs_n & s_q.sclk_prev & ~s_q.sync.sclk;
    assign sclk_rise = ~s_q.sync.cs_n & ~s_q.sclk_prev & s_q.sync.sclk;

    ////////////////////////////////////////////////////////////////////
    // RULE9: crc-8 frame check
    sfp_crc8 u_crc_rx (
        .data (s_q.rx[31:8]),
        .crc  (crc_rx)
    );

    // RULE11: address, data, crc fields
    assign wr_addr   = s_q.rx[31:24];
    assign wr_data   = s_q.rx[23:8];
    // RULE18: crc must match
    assign crc_ok    = (crc_rx == s_q.rx[7:0]);
    // RULE19: exactly 32 falling edges
    assign len_ok    = (s_q.cnt == FRAME_BITS);
    // RULE21: act only at cs rise
    assign wr_fire   = cs_rise & len_ok & crc_ok;
    assign frame_err = cs_rise & ~(len_ok & crc_ok);

    ////////////////////////////////////////////////////////////////////
    // RULE4: live view of conditions
    always_comb begin
        live                                  = REG_RESET;
        live[BIT_DIE_HOT]                     = s_q.sync.cond.die_hot;
        live[BIT_SUPPLY0 +: NUM_SUPPLY]       = s_q.sync.cond.supply_low;
        live[BIT_MODEM]                       = s_q.sync.cond.modem_fault;
        live[BIT_CHAN]                        = s_q.sync.cond.chan_fault;
    end

    ////////////////////////////////////////////////////////////////////
    // readback mux by selected address
    always_comb begin
        case (s_q.rbsel[RB_ADDR_MSB:0])
            ADDR_FAULT_LATCH: rd_data = s_q.latch;
            ADDR_FAULT_MASK:  rd_data = s_q.mask;
            ADDR_LIVE_FAULT:  rd_data = live;
            ADDR_HEAT_RESET:  rd_data = {15'h0000, s_q.heat_en};
            ADDR_RB_SELECT:   rd_data = s_q.rbsel;
            default:          rd_data = REG_RESET;
        endcase
    end

    // RULE16: pointer when select clear
    // RULE17: status flags when select set
    assign mid     = s_q.rbsel[RB_STATUS_SEL]
                   ? {s_q.sync.pin_in, s_q.sync.cond.conv_done, s_q.sync.cond.modem_fault,
                      3'h0, s_q.sync.cond.comp_level}
                   : s_q.rbsel[RB_PTR_MSB:0];
    // RULE15: data then crc
    assign tx_head = {1'b1, mid, rd_data};

    sfp_crc8 u_crc_tx (
        .data (tx_head),
        .crc  (crc_tx)
    );

    // RULE20: second key right after first
    assign key_hit = wr_fire & (wr_addr == ADDR_CMD_KEY) & s_q.key_armed & (wr_data == KEY_SECOND);

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_d           = s_q;
        s_d.meta      = pins;
        s_d.sync      = s_q.meta;
        s_d.sclk_prev = s_q.sync.sclk;
        s_d.cs_prev   = s_q.sync.cs_n;
        // RULE21: restart count at cs fall
        if (cs_fall) begin
            s_d.cnt = 6'h00;
            s_d.tx  = {tx_head, crc_tx};
            // RULE14: bit31 one at cs fall
            s_d.sdo = 1'b1;
        end else begin
            if (sclk_fall) begin
                s_d.rx  = {s_q.rx[30:0], s_q.sync.sdi};
                s_d.cnt = (s_q.cnt == CNT_MAX) ? CNT_MAX : s_q.cnt + 6'h01;
            end
            // RULE13: shift readback out msb first
            if (sclk_rise) begin
                s_d.tx  = {s_q.tx[30:0], 1'b0};
                s_d.sdo = s_q.tx[30];
            end
        end
        // RULE1 RULE6 RULE7: latch every live register bit
        // RULE2: write one clears, set wins
        s_d.latch = s_q.latch & ~((wr_fire && wr_addr == ADDR_FAULT_LATCH) ? wr_data : REG_RESET);
        s_d.latch = s_d.latch | live;
        s_d.latch[BIT_FRAME_ERR] = s_d.latch[BIT_FRAME_ERR] | frame_err;
        // register writes
        if (wr_fire) begin
            s_d.key_armed = 1'b0;
            case (wr_addr)
                ADDR_FAULT_MASK: s_d.mask    = wr_data;
                ADDR_HEAT_RESET: s_d.heat_en = wr_data[HEAT_EN_BIT];
                // RULE12: select register for reads
                ADDR_RB_SELECT:  s_d.rbsel   = wr_data;
                ADDR_CMD_KEY:    s_d.key_armed = (wr_data == KEY_FIRST);
                ADDR_NOP:        s_d.key_armed = 1'b0;
                default:         s_d.key_armed = 1'b0;
            endcase
        end
        // RULE8: heat reset only when enabled
        s_d.rst_req = key_hit | (s_q.heat_en & s_q.sync.cond.die_reset);
        // RULE5: mask gates fault pin
        s_d.pin_oe  = |(s_q.latch & ~s_q.mask);
        if (rst || s_q.rst_req) begin
            s_d              = '0;
            s_d.meta.cs_n    = 1'b1;
            s_d.sync.cs_n    = 1'b1;
            s_d.cs_prev      = 1'b1;
            s_d.meta.pin_in  = 1'b1;
            s_d.sync.pin_in  = 1'b1;
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign sdo          = s_q.sdo;
    assign fault_pin_o  = s_q.rst_req & 1'b0;
    assign fault_pin_oe = s_q.pin_oe;
    assign dev_reset    = s_q.rst_req;

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence s_key_first;
        wr_fire && wr_addr == ADDR_CMD_KEY && wr_data == KEY_FIRST;
    endsequence

    sequence s_key_second;
        wr_fire && wr_addr == ADDR_CMD_KEY && wr_data == KEY_SECOND;
    endsequence

    property p_pin_drive;
        @(posedge core_clk) disable iff (rst)
        ((s_q.latch & ~s_q.mask) != 16'h0000) && !s_q.rst_req |=> fault_pin_oe;
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("fault pin not driven"); // RULE1

    property p_mask_block;
        @(posedge core_clk) disable iff (rst)
        ((s_q.latch & ~s_q.mask) == 16'h0000) && !s_q.rst_req |=> !fault_pin_oe;
    endproperty
    a_mask_block: assert property (p_mask_block) else $error("masked fault drove pin"); // RULE5

    property p_clear_all;
        @(posedge core_clk) disable iff (rst)
        wr_fire && wr_addr == ADDR_FAULT_LATCH && wr_data == CLEAR_ALL && live == 16'h0000
            && !s_q.rst_req |=> s_q.latch == 16'h0000;
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("latch not cleared"); // RULE2

    property p_supply_latch;
        @(posedge core_clk) disable iff (rst)
        s_q.sync.cond.supply_low != 6'h00 && !s_q.rst_req
            |=> (s_q.latch[BIT_SUPPLY0 +: NUM_SUPPLY] & $past(s_q.sync.cond.supply_low))
                == $past(s_q.sync.cond.supply_low);
    endproperty
    a_supply_latch: assert property (p_supply_latch) else $error("supply fault not latched"); // RULE6

    property p_hot_latch;
        @(posedge core_clk) disable iff (rst)
        s_q.sync.cond.die_hot && !s_q.rst_req |=> s_q.latch[BIT_DIE_HOT];
    endproperty
    a_hot_latch: assert property (p_hot_latch) else $error("die hot not latched"); // RULE7

    property p_heat_reset;
        @(posedge core_clk) disable iff (rst)
        s_q.heat_en && s_q.sync.cond.die_reset && !s_q.rst_req |=> dev_reset ##1 !dev_reset;
    endproperty
    a_heat_reset: assert property (p_heat_reset) else $error("heat reset missing"); // RULE8

    property p_soft_reset;
        @(posedge core_clk) disable iff (rst)
        s_q.key_armed && !s_q.rst_req ##0 s_key_second |=> dev_reset;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset missing"); // RULE20

    property p_key_arm;
        @(posedge core_clk) disable iff (rst)
        s_key_first ##0 !s_q.rst_req |=> s_q.key_armed;
    endproperty
    a_key_arm: assert property (p_key_arm) else $error("first key not armed"); // RULE20

    property p_msb_one;
        @(posedge core_clk) disable iff (rst)
        cs_fall && !s_q.rst_req |=> sdo && s_q.cnt == 6'h00;
    endproperty
    a_msb_one: assert property (p_msb_one) else $error("bit31 not one at cs fall"); // RULE14

    property p_bad_len;
        @(posedge core_clk) disable iff (rst)
        cs_rise && !len_ok && !s_q.rst_req |=> s_q.latch[BIT_FRAME_ERR] ##1 fault_pin_oe || s_q.mask[BIT_FRAME_ERR];
    endproperty
    a_bad_len: assert property (p_bad_len) else $error("bad length not flagged"); // RULE19

    property p_bad_crc;
        @(posedge core_clk) disable iff (rst)
        cs_rise && len_ok && !crc_ok && !s_q.rst_req |=> s_q.latch[BIT_FRAME_ERR] && $stable(s_q.mask)
            && $stable(s_q.rbsel);
    endproperty
    a_bad_crc: assert property (p_bad_crc) else $error("bad crc frame acted on"); // RULE18

    property p_pointer;
        @(posedge core_clk) disable iff (rst)
        cs_fall && !s_q.rbsel[RB_STATUS_SEL] && !s_q.rst_req |=> s_q.tx[30:24] == $past(s_q.rbsel[RB_PTR_MSB:0]);
    endproperty
    a_pointer: assert property (p_pointer) else $error("pointer field wrong"); // RULE16

endmodule

// >>> sfp_host.sv
/*
 * host model: serial main sending 32-bit frames with crc-8, msb first.
 * assumes the core samples sclk, cs_n and sdi on its own clock.
 */
`timescale 1ns/10ps
module sfp_host (
    // serial port pins
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi,
    input  wire logic sdo
);
    localparam int HALF = 160;

    ////////////////////////////////////////////////////////////////////
    // idle pins: clock stands high, chip deselected
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end

    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction

    // frame of nbits; sdo caught just before each rise
    task automatic frame(input logic [7:0] a, input logic [15:0] d, input logic bad,
                         input int nbits, output logic [31:0] rd);
        logic [31:0] w;
        w = {a, d, crc8({a, d}) ^ {7'h00, bad}};
        rd = 32'h0;
        #5; // keep pin changes off the core clock edge
        cs_n = 1'b0;
        #(2*HALF);
        // data set while clock high, msb first
        for (int i = 31; i > 31 - nbits; i--) begin
            sdi = w[i];
            #(HALF);
            sclk = 1'b0;
            #(HALF - 10);
            rd[i] = sdo;
            #10;
            sclk = 1'b1;
        end
        #(HALF);
        cs_n = 1'b1;
        sdi  = ~sdi; // released line shows inverse
        #(8*HALF - 5);
    endtask
endmodule

// >>> test_sfp_core.sv
/*
 * self-checking bench for the serial register port with fault reporting.
 * assumes sfp_host as far side; fault wire pulled up in the bench.
 */
`timescale 1ns/10ps
module test_sfp_core import sfp_pkg::*;;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        sclk, cs_n, sdi, sdo, fault_pin_o, fault_pin_oe, dev_reset, fault_wire;
    sfp_cond_t   cond = '0;
    integer      seed = 32'h353c;
    int          err_count = 0;
    int          n_checks = 0;
    int          n_rst = 0;
    logic [31:0] exp_q[$];
    logic [31:0] got_q[$];
    string       name_q[$];
    logic [15:0] lat, v;
    logic [31:0] r;
    int          b;

    ////////////////////////////////////////////////////////////////////
    // design, host and pulled-up fault wire
    assign fault_wire = (fault_pin_oe === 1'b1) ? fault_pin_o : 1'b1;
    sfp_core sfp_core_inst (.core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo(sdo), .fault_pin_i(fault_wire), .fault_pin_o(fault_pin_o),
        .fault_pin_oe(fault_pin_oe), .cond(cond), .dev_reset(dev_reset));
    sfp_host sfp_host_inst (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

    // clock and reset pulse counter
    initial forever #20 core_clk = ~core_clk;
    always @(posedge core_clk) if (dev_reset === 1'b1) n_rst++;

    ////////////////////////////////////////////////////////////////////
    // watcher: oldest note against each result
    initial forever begin
        @(posedge core_clk);
        if (got_q.size() > 0) begin
            n_checks++;
            if (got_q[0] !== exp_q[0]) begin
                $display("ERROR %s expected %h seen %h", name_q[0], exp_q[0], got_q[0]);
                err_count++;
            end
            void'(got_q.pop_front());
            void'(exp_q.pop_front());
            void'(name_q.pop_front());
        end
    end

    task automatic note(input string nm, input logic [31:0] e, input logic [31:0] g);
        name_q.push_back(nm);
        exp_q.push_back(e);
        got_q.push_back(g);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        sfp_host_inst.frame(a, d, 1'b0, 32, r);
    endtask

    // two-frame read; expected word built before the second frame
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic sel, input logic [15:0] d);
        logic [23:0] t;
        wr(ADDR_RB_SELECT, {7'h00, sel, a});
        t = {1'b1, sel ? {fault_wire, cond.conv_done, cond.modem_fault, 3'h0, cond.comp_level}
                       : a[6:0], d};
        name_q.push_back(nm);
        exp_q.push_back({t, sfp_host_inst.crc8(t)});
        sfp_host_inst.frame(ADDR_NOP, 16'h0000, 1'b0, 32, r);
        got_q.push_back(r);
    endtask

    task automatic close_out();
        repeat (4) @(posedge core_clk);
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (90000) @(posedge core_clk);
        err_count++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        repeat (5) @(posedge core_clk);
        rd_chk("latch", ADDR_FAULT_LATCH, 1'b0, REG_RESET);
        lat = 16'h0000;
        for (int k = 0; k < 3; k++) begin
            v = 16'($random(seed));
            @(posedge core_clk);
            cond <= '{supply_low: v[5:0], die_hot: 1'b1, chan_fault: k[0], default: 1'b0};
            repeat (8) @(posedge core_clk);
            v = {6'h00, k[0], 1'b0, v[5:0], 2'b10};
            lat = lat | v;
            rd_chk("live", ADDR_LIVE_FAULT, 1'b0, v);
            note("pin", 32'h1, {31'h0, fault_pin_oe});
        end
        cond <= '0;
        repeat (8) @(posedge core_clk);
        rd_chk("live", ADDR_LIVE_FAULT, 1'b0, 16'h0000);
        rd_chk("latch", ADDR_FAULT_LATCH, 1'b0, lat);
        // sub-registers are absent, so the main latch is cleared directly
        wr(ADDR_FAULT_LATCH, 16'h0006);
        rd_chk("latch", ADDR_FAULT_LATCH, 1'b0, lat & 16'hfff9);
        wr(ADDR_FAULT_MASK, CLEAR_ALL);
        note("pin", 32'h0, {31'h0, fault_pin_oe});
        note("pin level", 32'h0, {31'h0, fault_pin_o});
        v = 16'($random(seed));
        wr(ADDR_FAULT_MASK, v);
        rd_chk("mask", ADDR_FAULT_MASK, 1'b0, v);
        wr(ADDR_FAULT_MASK, 16'h0000);
        wr(ADDR_FAULT_LATCH, CLEAR_ALL);
        rd_chk("latch", ADDR_FAULT_LATCH, 1'b0, 16'h0000);
        note("pin", 32'h0, {31'h0, fault_pin_oe});
        // bad check byte, then short frame
        for (int k = 0; k < 2; k++) begin
            sfp_host_inst.frame(ADDR_FAULT_MASK, 16'h1234, k == 0, 32 - k, r);
            rd_chk("mask", ADDR_FAULT_MASK, 1'b0, 16'h0000);
            rd_chk("latch", ADDR_FAULT_LATCH, 1'b0, 16'h0001);
            note("pin", 32'h1, {31'h0, fault_pin_oe});
            wr(ADDR_FAULT_LATCH, CLEAR_ALL);
        end
        @(posedge core_clk);
        cond <= '{modem_fault: 1'b1, conv_done: 1'b1, comp_level: 1'b1, default: 1'b0};
        repeat (8) @(posedge core_clk);
        rd_chk("status", ADDR_LIVE_FAULT, 1'b1, 16'h0100);
        cond <= '0;
        repeat (8) @(posedge core_clk);
        wr(ADDR_FAULT_LATCH, CLEAR_ALL);
        // key pair, then key pair broken by a nop
        wr(ADDR_FAULT_MASK, 16'h00a5);
        b = n_rst;
        wr(ADDR_CMD_KEY, KEY_FIRST);
        wr(ADDR_CMD_KEY, KEY_SECOND);
        note("key reset", 32'h1, 32'(n_rst - b));
        rd_chk("mask", ADDR_FAULT_MASK, 1'b0, REG_RESET);
        b = n_rst;
        wr(ADDR_CMD_KEY, KEY_FIRST);
        wr(ADDR_NOP, 16'h0000);
        wr(ADDR_CMD_KEY, KEY_SECOND);
        note("key reset", 32'h0, 32'(n_rst - b));
        // heat reset off, then on
        @(posedge core_clk);
        cond <= '{die_reset: 1'b1, default: 1'b0};
        repeat (20) @(posedge core_clk);
        note("heat reset", 32'h0, 32'(n_rst - b));
        wr(ADDR_HEAT_RESET, 16'h0001);
        note("heat reset", 32'h1, 32'(n_rst - b));
        cond <= '0;
        close_out();
    end
endmodule
